// file: ecg_sample_tag_and_rr_interval_bench.sv
`timescale 1ns/1ps
module ecg_sample_tag_and_rr_interval_bench;
  import ert_pkg::*;
  localparam int DEPTH = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] address;
  logic read, write, waitrequest, beat_interrupt, channel_resync;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic sample_valid = 1'b0;
  logic [VOLT_W-1:0] sample_voltage = '0;
  logic sample_fast = 1'b0;
  logic r_event = 1'b0;
  logic data_clk_pin = 1'b0;
  logic dclk_en = 1'b0;
  logic [3:0] dcnt = 4'h0;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] d;

  always #2.5 mclk = ~mclk;
  // ==========================================================
  // link clock, 160 ns period, still when disabled
  always @(posedge mclk) begin
    if (dclk_en) begin
      dcnt <= dcnt + 4'h1;
      if (dcnt == 4'hF) data_clk_pin <= ~data_clk_pin;
    end
  end

  ert_top #(.DEPTH(DEPTH)) ert_top_inst (.mclk(mclk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sample_valid(sample_valid),
    .sample_voltage(sample_voltage), .sample_fast(sample_fast),
    .r_event(r_event), .data_clk_pin(data_clk_pin),
    .beat_interrupt(beat_interrupt), .channel_resync(channel_resync));

  ert_host host_inst (.mclk(mclk), .waitrequest(waitrequest),
    .readdata(readdata), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable));

  // ==========================================================
  // helpers
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    host_inst.xfer(1'b0, a, 32'h0, q);
    if (host_inst.hang_cnt != 0) begin
      error_cnt++;
      final_report();
    end
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] q;
    host_inst.xfer(1'b1, a, v, q);
    if (host_inst.hang_cnt != 0) begin
      error_cnt++;
      final_report();
    end
  endtask : wr

  task automatic push(input logic [17:0] v, input logic f);
    @(posedge mclk);
    sample_valid <= 1'b1;
    sample_voltage <= v;
    sample_fast <= f;
    @(posedge mclk);
    sample_valid <= 1'b0;
  endtask : push

  task automatic pulse_r;
    @(posedge mclk);
    r_event <= 1'b1;
    @(posedge mclk);
    r_event <= 1'b0;
  endtask : pulse_r

  function automatic logic [31:0] sw(logic [17:0] v, logic [2:0] t);
    return {8'h00, v, t, 3'h0};
  endfunction : sw

  // ==========================================================
  // scenarios
  task automatic reset_state;
    chk("beat", 32'h0, {31'h0, beat_interrupt});
    rd(OFF_STATUS, d);
    chk("status", 32'h0, d);
    rd(OFF_GEN, d);
    chk("gen", 32'h1, d);
    rd(OFF_SAMPLE, d);
    chk("empty tag", 32'h6, {29'h0, d[5:3]});
  endtask : reset_state

  task automatic tag_kinds;
    push(18'h2AAAA, 1'b0);
    push(18'h15555, 1'b1);
    push(18'h3FFFF, 1'b1);
    rd(OFF_SAMPLE, d);
    chk("valid", sw(18'h2AAAA, 3'h0), d);
    rd(OFF_SAMPLE, d);
    chk("fast", sw(18'h15555, 3'h1), d);
    rd(OFF_SAMPLE, d);
    chk("fast eof", sw(18'h3FFFF, 3'h3), d);
    push(18'h00001, 1'b0); // reads resume only after new data
    rd(OFF_SAMPLE, d);
    chk("valid eof", sw(18'h00001, 3'h2), d);
    rd(OFF_SAMPLE, d);
    chk("empty", 32'h6, {29'h0, d[5:3]});
  endtask : tag_kinds

  task automatic overflow;
    for (int i = 0; i <= DEPTH; i++) push(18'(i + 16), 1'b0);
    rd(OFF_STATUS, d);
    chk("ovf flag", 32'h1, {31'h0, d[0]});
    rd(OFF_SAMPLE, d);
    chk("ovf tag", 32'h7, {29'h0, d[5:3]});
    wr(OFF_CMD, 32'h1);
    rd(OFF_STATUS, d);
    chk("after reset", 32'h0, d);
    push(18'h12345, 1'b0);
    rd(OFF_SAMPLE, d);
    chk("post reset", sw(18'h12345, 3'h2), d);
  endtask : overflow

  task automatic rr_case(input logic [1:0] div, input int edges);
    int n;
    n = 0;
    wr(OFF_MNGR, 32'h1);
    wr(OFF_GEN, {30'h0, div});
    // align on a fresh rising edge of the data clock
    while (data_clk_pin !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    while (data_clk_pin !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100) begin
      error_cnt++;
      final_report();
    end
    repeat (8) @(posedge mclk);
    pulse_r();
    repeat (32 * edges) @(posedge mclk);
    pulse_r();
    repeat (2) @(posedge mclk);
    chk("beat set", 32'h1, {31'h0, beat_interrupt});
    rd(OFF_INTERVAL, d);
    chk("interval", {8'h00, 14'(edges / div), 10'h0}, d);
    @(posedge mclk);
    chk("clr ivl", 32'h0, {31'h0, beat_interrupt});
  endtask : rr_case

  task automatic beat_modes;
    wr(OFF_MNGR, 32'h0);
    pulse_r();
    repeat (2) @(posedge mclk);
    rd(OFF_STATUS, d);
    chk("st beat", 32'h1, {31'h0, d[1]});
    @(posedge mclk);
    chk("clr st", 32'h0, {31'h0, beat_interrupt});
    wr(OFF_MNGR, 32'h2);
    pulse_r();
    push(18'h00100, 1'b0);
    repeat (2) @(posedge mclk);
    chk("self hold", 32'h1, {31'h0, beat_interrupt});
    push(18'h00200, 1'b0);
    repeat (2) @(posedge mclk);
    chk("self clr", 32'h0, {31'h0, beat_interrupt});
  endtask : beat_modes

  task automatic resync;
    int n;
    n = 0;
    wr(OFF_CMD, 32'h2);
    while (channel_resync !== 1'b1 && n < 5) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 5) begin
      error_cnt++;
      final_report();
    end
    chk("resync", 32'h1, {31'h0, channel_resync});
    @(posedge mclk);
    chk("resync pulse", 32'h0, {31'h0, channel_resync});
    rd(OFF_SAMPLE, d);
    chk("resync empty", 32'h6, {29'h0, d[5:3]});
  endtask : resync

  task automatic read_only;
    logic [31:0] keep;
    rd(OFF_INTERVAL, keep);
    wr(OFF_INTERVAL, 32'hFFFFFFFF);
    rd(OFF_INTERVAL, d);
    chk("ro ivl", keep, d);
    chk("ivl low", 32'h0, {22'h0, d[9:0]});
    rd(8'h3C, d);
    chk("unmapped", 32'h0, d);
  endtask : read_only

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    reset_state();
    tag_kinds();
    overflow();
    dclk_en <= 1'b1;
    rr_case(2'h1, 5);
    rr_case(2'h2, 6);
    dclk_en <= 1'b0;
    beat_modes();
    resync();
    read_only();
    final_report();
  end
endmodule : ecg_sample_tag_and_rr_interval_bench

// file: ert_host.sv
`timescale 1ns/1ps
module ert_host (
  input wire logic mclk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [ert_pkg::ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable
);
  import ert_pkg::*;
  int hang_cnt = 0;
  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hF;
  end
  // ==========================================================
  // bus cycle
  // request held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) hang_cnt++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // released data must not look like the last value
    writedata <= ~wd;
  endtask : xfer
endmodule : ert_host

// file: ert_pkg.sv
// Behaviour
// - sample tag sits in word bits five..three
// - tag 000 for ordinary valid sample
// - tag 001 for fast settling sample
// - tag 010 for last valid sample
// - tag 011 for last fast sample
// - tag 110 when reading empty buffer
// - tag 111 after buffer overflow
// - overflow also shown by status flag
// - buffer reset command clears overflowed buffer
// - resynchronise restarts timing and clears buffer
// - interval register read-only, left justified
// - interval spans the two latest R events
// - interval count step set by configuration
// - R event updates interval, raises beat interrupt
// - clear select 01 clears on interval read
// - clear select 00 clears on status read
// - clear select 10 self-clears after two data cycles
// - interval counter wraps without raising interrupt
// - voltage is 18-bit, left justified
package ert_pkg;
  // ==========================================================
  // bus map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MNGR = 8'h04;
  localparam logic [7:0] OFF_GEN = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0C;
  localparam logic [7:0] OFF_SAMPLE = 8'h10;
  localparam logic [7:0] OFF_INTERVAL = 8'h14;
  // ==========================================================
  // fields and reset values
  localparam int ST_OVF_BIT = 0;
  localparam int ST_BEAT_BIT = 1;
  localparam int ST_CNT_LSB = 8;
  localparam int CMD_FIFO_RST_BIT = 0;
  localparam int CMD_RESYNC_BIT = 1;
  localparam int TAG_LSB = 3;
  localparam int VOLT_LSB = 6;
  localparam int VOLT_W = 18;
  localparam int IVL_W = 14;
  localparam int IVL_LSB = 10;
  localparam int PRESC_W = 16;
  localparam logic [15:0] GEN_DIV_RST = 16'h0001;
  localparam logic [1:0] CLR_SEL_RST = 2'h0;
  localparam logic [1:0] DATA_CYCLES_SELF_CLR = 2'h2;
  // ==========================================================
  // codes
  localparam logic [1:0] CLR_ON_STATUS = 2'h0;
  localparam logic [1:0] CLR_ON_INTERVAL = 2'h1;
  localparam logic [1:0] CLR_SELF = 2'h2;
  localparam logic [2:0] TAG_VALID = 3'h0;
  localparam logic [2:0] TAG_FAST = 3'h1;
  localparam logic [2:0] TAG_VALID_EOF = 3'h2;
  localparam logic [2:0] TAG_FAST_EOF = 3'h3;
  localparam logic [2:0] TAG_EMPTY = 3'h6;
  localparam logic [2:0] TAG_OVERFLOW = 3'h7;
endpackage : ert_pkg

// file: ert_top.sv
`timescale 1ns/1ps
module ert_top #(
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ert_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic sample_valid,
  input wire logic [ert_pkg::VOLT_W-1:0] sample_voltage,
  input wire logic sample_fast,
  input wire logic r_event,
  input wire logic data_clk_pin,
  output logic beat_interrupt,
  output logic channel_resync
);
  import ert_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // ==========================================================
  // elaboration check
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 2");
  end

  // ==========================================================
  // bus slave
  logic waitrequest_ff;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_rdata;
  logic bus_go;
  logic req_first;
  logic pop_pend_ff;
  logic pop_go;
  logic buf_clear;
  logic resync_go;
  logic status_rd_go;
  logic ivl_rd_go;
  logic [1:0] clr_sel_ff;
  logic [15:0] gen_div_ff;
  logic overflow_ff;
  logic beat_irq_ff;
  logic [IVL_W-1:0] beat_interval_ff;
  logic [CW-1:0] count_ff;
  logic [2:0] head_tag;
  logic [VOLT_W-1:0] head_volt;

  assign bus_go = (read || write) && !waitrequest_ff;
  assign req_first = (read || write) && waitrequest_ff;
  assign status_rd_go = bus_go && read && address == OFF_STATUS;
  assign ivl_rd_go = bus_go && read && address == OFF_INTERVAL;
  assign pop_go = bus_go && read && address == OFF_SAMPLE && pop_pend_ff;
  assign resync_go = bus_go && write && address == OFF_CMD &&
                     byteenable[0] && writedata[CMD_RESYNC_BIT];
  assign buf_clear = resync_go || (bus_go && write && address == OFF_CMD &&
                     byteenable[0] && writedata[CMD_FIFO_RST_BIT]);

  // one wait state, then the access takes effect
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest_ff <= 1'b1;
    end else begin
      waitrequest_ff <= !req_first;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (address)
      OFF_STATUS: begin
        nxt_rdata[ST_OVF_BIT] = overflow_ff;
        nxt_rdata[ST_BEAT_BIT] = beat_irq_ff;
        nxt_rdata[ST_CNT_LSB +: CW] = count_ff;
      end
      OFF_MNGR: nxt_rdata[1:0] = clr_sel_ff;
      OFF_GEN: nxt_rdata[15:0] = gen_div_ff;
      OFF_SAMPLE: begin
        nxt_rdata[VOLT_LSB +: VOLT_W] = head_volt;
        nxt_rdata[TAG_LSB +: 3] = head_tag;
      end
      OFF_INTERVAL: nxt_rdata[IVL_LSB +: IVL_W] = beat_interval_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_ff <= 32'h0000_0000;
    end else if (req_first && read) begin
      readdata_ff <= nxt_rdata;
    end
  end

  // remembers whether the word handed out was a real entry
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pop_pend_ff <= 1'b0;
    end else if (req_first) begin
      pop_pend_ff <= read && address == OFF_SAMPLE && count_ff != '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clr_sel_ff <= CLR_SEL_RST;
      gen_div_ff <= GEN_DIV_RST;
    end else if (bus_go && write) begin
      if (address == OFF_MNGR && byteenable[0]) begin
        clr_sel_ff <= writedata[1:0];
      end
      if (address == OFF_GEN && byteenable[0]) begin
        gen_div_ff[7:0] <= writedata[7:0];
      end
      if (address == OFF_GEN && byteenable[1]) begin
        gen_div_ff[15:8] <= writedata[15:8];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      channel_resync <= 1'b0;
    end else begin
      channel_resync <= resync_go;
    end
  end

  assign readdata = readdata_ff;
  assign waitrequest = waitrequest_ff;
  assign beat_interrupt = beat_irq_ff;

  // ==========================================================
  // sample buffer
  logic [VOLT_W:0] mem_ff [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic full;
  logic do_wr;
  logic [AW-1:0] wr_idx;

  assign full = count_ff == CW'(DEPTH);
  assign do_wr = sample_valid && (buf_clear || !full);
  assign wr_idx = buf_clear ? '0 : wptr_ff;
  assign head_volt = mem_ff[rptr_ff][VOLT_W-1:0];

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem_ff[wr_idx] <= {sample_fast, sample_voltage};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
    end else if (buf_clear) begin
      rptr_ff <= '0;
      wptr_ff <= do_wr ? AW'(1) : '0;
      count_ff <= do_wr ? CW'(1) : '0;
    end else begin
      if (do_wr) begin
        wptr_ff <= wptr_ff + AW'(1);
      end
      if (pop_go) begin
        rptr_ff <= rptr_ff + AW'(1);
      end
      count_ff <= count_ff + CW'(do_wr) - CW'(pop_go);
    end
  end

  // sticky overflow flag, a write into a full buffer sets it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_ff <= 1'b0;
    end else if (sample_valid && full && !buf_clear) begin
      overflow_ff <= 1'b1;
    end else if (buf_clear) begin
      overflow_ff <= 1'b0;
    end
  end

  always_comb begin
    head_tag = TAG_VALID;
    if (overflow_ff) begin
      head_tag = TAG_OVERFLOW;
    end else if (count_ff == '0) begin
      head_tag = TAG_EMPTY;
    end else if (count_ff == CW'(1)) begin
      head_tag = mem_ff[rptr_ff][VOLT_W] ? TAG_FAST_EOF : TAG_VALID_EOF;
    end else begin
      head_tag = mem_ff[rptr_ff][VOLT_W] ? TAG_FAST : TAG_VALID;
    end
  end

  // ==========================================================
  // interval time base
  logic link_s1_ff;
  logic link_s2_ff;
  logic link_s3_ff;
  logic link_rise;
  logic [PRESC_W-1:0] presc_ff;
  logic [15:0] div_eff;
  logic tick;
  logic [IVL_W-1:0] ivl_cnt_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link_s1_ff <= 1'b0;
      link_s2_ff <= 1'b0;
      link_s3_ff <= 1'b0;
    end else begin
      link_s1_ff <= data_clk_pin;
      link_s2_ff <= link_s1_ff;
      link_s3_ff <= link_s2_ff;
    end
  end

  assign link_rise = link_s2_ff && !link_s3_ff;
  assign div_eff = (gen_div_ff == 16'h0000) ? 16'h0001 : gen_div_ff;
  // one count per div_eff rising data clock edges
  assign tick = link_rise && presc_ff == PRESC_W'(div_eff - 16'h0001);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      presc_ff <= '0;
    end else if (resync_go || r_event || tick) begin
      presc_ff <= '0;
    end else if (link_rise) begin
      presc_ff <= presc_ff + PRESC_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ivl_cnt_ff <= '0;
    end else if (resync_go || r_event) begin
      ivl_cnt_ff <= '0;
    end else if (tick) begin
      ivl_cnt_ff <= ivl_cnt_ff + IVL_W'(1);
    end
  end

  // capture interval on each R event
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      beat_interval_ff <= '0;
    end else if (r_event) begin
      beat_interval_ff <= ivl_cnt_ff;
    end
  end

  // ==========================================================
  // beat interrupt term
  logic [1:0] cyc_cnt_ff;
  logic beat_clr;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_cnt_ff <= '0;
    end else if (r_event) begin
      cyc_cnt_ff <= '0;
    end else if (sample_valid && cyc_cnt_ff != DATA_CYCLES_SELF_CLR) begin
      cyc_cnt_ff <= cyc_cnt_ff + 2'h1;
    end
  end

  always_comb begin
    unique case (clr_sel_ff)
      CLR_ON_INTERVAL: beat_clr = ivl_rd_go;
      // clear after two whole data cycles
      CLR_SELF: beat_clr = cyc_cnt_ff == DATA_CYCLES_SELF_CLR;
      default: beat_clr = status_rd_go;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      beat_irq_ff <= 1'b0;
    end else if (r_event) begin
      beat_irq_ff <= 1'b1;
    end else if (beat_clr) begin
      beat_irq_ff <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  sequence req_wait_s;
    (read || write) && waitrequest_ff;
  endsequence
  sequence answer_s;
    !waitrequest_ff ##1 waitrequest_ff;
  endsequence

  property one_wait_p;
    @(posedge mclk) disable iff (!rst_n)
      req_wait_s |=> answer_s;
  endproperty
  bus_one_wait_a: assert property (one_wait_p) // bus handshake
    else $error("waitrequest timing broken");

  sample_word_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
      req_wait_s and read && address == OFF_SAMPLE
      |=> readdata_ff[2:0] == 3'h0 && readdata_ff[31:24] == 8'h00)
    else $error("sample word layout wrong");

  empty_tag_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
      req_wait_s and read && address == OFF_SAMPLE && count_ff == '0 &&
      !overflow_ff |=> readdata_ff[5:3] == TAG_EMPTY)
    else $error("empty tag missing");

  overflow_tag_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
      req_wait_s and read && address == OFF_SAMPLE && overflow_ff
      |=> readdata_ff[5:3] == TAG_OVERFLOW)
    else $error("overflow tag missing");

  last_tag_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
      req_wait_s and read && address == OFF_SAMPLE && count_ff == CW'(1)
      && !overflow_ff |=> readdata_ff[5:4] == 2'h1)
    else $error("end-of-data tag missing");

  overflow_flag_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
      sample_valid && full && !buf_clear
      |=> overflow_ff ##1 (overflow_ff || $past(buf_clear)))
    else $error("overflow flag not set");

  buffer_clear_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
      buf_clear |=> !overflow_ff && count_ff <= CW'(1))
    else $error("buffer not cleared");

  interval_zeros_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
      req_wait_s and read && address == OFF_INTERVAL
      |=> readdata_ff[9:0] == 10'h000 && readdata_ff[31:24] == 8'h00)
    else $error("interval low bits not zero");

  beat_update_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
      r_event |=> beat_irq_ff && beat_interval_ff == $past(ivl_cnt_ff))
    else $error("beat event not captured");

  counter_wrap_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
      tick && !r_event && !resync_go && &ivl_cnt_ff
      |=> ivl_cnt_ff == '0 && $stable(beat_interval_ff) &&
      !$rose(beat_irq_ff))
    else $error("counter wrap wrong");

  status_clear_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
      status_rd_go && clr_sel_ff == CLR_ON_STATUS && !r_event
      |=> !beat_irq_ff)
    else $error("status read did not clear beat term");
endmodule : ert_top
